// File: rtl/wdt_top.sv
// 16-bit timer with normal and watchdog modes, reached over APB.
// Assumes presetn is the power-on reset only; other system resets do not
// reach this block, so the count and configuration survive them.
// Assumes the debugger and power-down status arrive on the pclk domain.
// Notes on behaviour
// [RULE1] Service write, watchdog zero or periodic overflow loads reload value
// [RULE2] Counts 32.768 kHz ticks through 1/16/256 prescaler
// [RULE3] Captures count when enabled overflow interrupt fires
// [RULE4] Control bit 5 enters watchdog down-count mode
// [RULE5] Full reload with divide-by-256 gives 512 s
// [RULE6] Software keeps timeouts at 30 ms or more
// [RULE7] Zero in watchdog raises reset or interrupt
// [RULE8] Service write before zero restarts the timeout
// [RULE9] Watchdog mode locks reload and control registers
// [RULE10] Only power-on reset clears counter and configuration
// [RULE11] Counter halts while debugger owns core
// [RULE12] Bit 0 stops counting during peripheral power-down
// [RULE13] Control bit 8 selects up or down
// [RULE14] Control bit 7 enables counting
// [RULE15] Control bit 6 selects periodic or free-running
// [RULE16] Control bit 4 enables secure clear
// [RULE17] Prescaler code 00 divides by one
// [RULE18] Reload and count are 16 bits, 0x03D7
// [RULE19] Service write clears pending timer interrupt
// [RULE20] Software writes zero to reserved control bits
// [RULE21] Secure service must match LFSR next value
// [RULE22] Zero seed or value forces reset; LFSR hidden
// [RULE23] Interrupt stays until the service write
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module wdt_top (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator pin and system status
  input wire logic osc_32k,
  input wire wdt_pkg::wdt_sys_t sys_in,
  // Events towards the system
  output logic timer_irq,
  output logic wdog_reset_req
);

  // Oscillator synchroniser and filtered level
  logic osc_s1_q, osc_s2_q, osc_s3_q, osc_lvl_q, osc_lvl_d;
  logic osc_rise;

  // APB answer registers
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // Timer state
  wdt_pkg::wdt_ctrl_t ctrl_q, ctrl_d;
  logic [15:0] reload_q, reload_d;
  logic [15:0] count_q, count_d;
  logic [15:0] capture_q, capture_d;
  logic [7:0] pre_q, pre_d;
  logic [7:0] lfsr_q, lfsr_d;  // Never readable
  logic irq_q, irq_d;
  logic [2:0] rst_cnt_q, rst_cnt_d;
  logic rst_req_q, rst_req_d;

  // Decoded helpers
  logic setup_ph, wr_take, svc_wr, halted, tick, fire, overflow;
  logic [7:0] div_last, lfsr_next;
  logic hit_reload, hit_count, hit_ctrl, hit_svc, hit_cap, secure_bad;

  // Synchroniser: only stage two reads stage one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      osc_lvl_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_32k;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      osc_lvl_q <= osc_lvl_d;
    end
  end

  // Level changes only once stages two and three agree
  // Filter resets low: a pin already high at release gives one early
  // rise, harmless because the control register is still clear then
  always_comb begin
    osc_lvl_d = (osc_s2_q == osc_s3_q) ? osc_s3_q : osc_lvl_q;
    osc_rise = osc_lvl_d & ~osc_lvl_q;
  end

  // Address decode, full 32-bit compare
  assign hit_reload = (paddr == wdt_pkg::ADDR_RELOAD);
  assign hit_count = (paddr == wdt_pkg::ADDR_COUNT);
  assign hit_ctrl = (paddr == wdt_pkg::ADDR_CONTROL);
  assign hit_svc = (paddr == wdt_pkg::ADDR_SERVICE);
  assign hit_cap = (paddr == wdt_pkg::ADDR_CAPTURE);
  assign setup_ph = psel & ~penable;
  // Write takes effect on the access edge where pready is seen high
  assign wr_take = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign svc_wr = wr_take & hit_svc;

  // APB answer: no wait state, answer prepared during the setup cycle
  // Registered answer costs no cycle and keeps decode off the output pins
  always_comb begin
    pready_d = setup_ph;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (setup_ph) begin
      if (pwrite) begin
        // Writes to read-only or unmapped words are refused
        pslverr_d = ~(hit_reload | hit_ctrl | hit_svc);
      end else begin
        // Service register reads zero; LFSR state stays hidden
        if (hit_reload) begin
          prdata_d = {16'h0000, reload_q};
        end else if (hit_count) begin
          prdata_d = {16'h0000, count_q};
        end else if (hit_ctrl) begin
          prdata_d = {16'h0000, ctrl_q};
        end else if (hit_cap) begin
          prdata_d = {16'h0000, capture_q};
        end else if (!hit_svc) begin
          pslverr_d = 1'b1;
        end
      end
    end
  end

  // APB answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Prescaler last count; reserved code 11 falls back to divide-by-one
  // Limitation: the longest watchdog period needs the divide-by-256 code
  always_comb begin
    case (ctrl_q.presc)
      wdt_pkg::PRESC_DIV1: div_last = 8'h00;  // [RULE17]
      wdt_pkg::PRESC_DIV16: div_last = wdt_pkg::DIV16_LAST;  // [RULE2]
      wdt_pkg::PRESC_DIV256: div_last = wdt_pkg::DIV256_LAST;  // [RULE2] [RULE5]
      default: div_last = 8'h00;
    endcase
  end

  // Next LFSR state, Galois form shifting towards bit 7
  // Taps are fixed, so software can track the sequence on its own
  assign lfsr_next = {lfsr_q[6:0], 1'b0} ^ (lfsr_q[7] ? wdt_pkg::LFSR_TAPS : 8'h00);  // [RULE21]
  // Secure clear failure: wrong value or zero
  assign secure_bad = svc_wr & ctrl_q.wdog_mode & ctrl_q.secure &  // [RULE16]
                      ((pwdata[7:0] != lfsr_q) | (pwdata[7:0] == 8'h00));  // [RULE21] [RULE22]

  // Halt by debugger or by power-down when bit 0 asks for it
  // Halting the prescaler too keeps a partial period from being lost
  assign halted = sys_in.debug_halt |
                  (ctrl_q.stop_in_powerdown & sys_in.periph_pd);  // [RULE11] [RULE12]
  // Watchdog mode counts even with the enable bit clear
  assign tick = osc_rise & ~halted & (ctrl_q.enable | ctrl_q.wdog_mode) &
                (pre_q == div_last);  // [RULE14]
  // Terminal count: zero in watchdog mode, end of range in normal mode
  assign fire = tick & ctrl_q.wdog_mode & (count_q == wdt_pkg::COUNT_MIN);  // [RULE4]
  assign overflow = tick & ~ctrl_q.wdog_mode &
                    (ctrl_q.count_up ? (count_q == wdt_pkg::COUNT_MAX)
                                     : (count_q == wdt_pkg::COUNT_MIN));

  // Timer core next state
  always_comb begin
    ctrl_d = ctrl_q;
    reload_d = reload_q;
    count_d = count_q;
    capture_d = capture_q;
    pre_d = pre_q;
    lfsr_d = lfsr_q;
    irq_d = irq_q;
    // Pulse counter runs down to zero; a new trigger restarts it
    rst_cnt_d = (rst_cnt_q != 3'h0) ? rst_cnt_q - 3'h1 : 3'h0;
    // Locked once watchdog mode is on; only power-on reset unlocks
    if (wr_take && hit_ctrl && !ctrl_q.wdog_mode) begin  // [RULE9]
      ctrl_d = wdt_pkg::wdt_ctrl_t'(pwdata[15:0] & wdt_pkg::CONTROL_WMASK);  // [RULE20]
    end
    if (wr_take && hit_reload && !ctrl_q.wdog_mode) begin  // [RULE9]
      reload_d = pwdata[15:0];  // [RULE18]
    end
    // Prescaler advances on oscillator edges while not halted
    // A shorter new divider wraps the prescaler at its next edge
    if (osc_rise && !halted) begin
      pre_d = (pre_q >= div_last) ? 8'h00 : pre_q + 8'h01;
    end
    // Counting
    if (fire) begin
      count_d = reload_q;  // [RULE1]
      if (ctrl_q.irq_mode) begin
        irq_d = 1'b1;  // [RULE7]
      end else begin
        rst_cnt_d = wdt_pkg::RST_PULSE_CYC;  // [RULE7]
      end
    end else if (overflow) begin
      // Periodic reloads; free-running wraps around
      if (ctrl_q.periodic) begin  // [RULE15]
        count_d = reload_q;  // [RULE1]
      end else begin
        count_d = ctrl_q.count_up ? wdt_pkg::COUNT_MIN : wdt_pkg::COUNT_MAX;
      end
      irq_d = 1'b1;
      if (sys_in.irq_en) begin
        capture_d = count_q;  // [RULE3]
      end
    end else if (tick) begin
      // Watchdog ignores the direction bit and always counts down
      if (ctrl_q.count_up && !ctrl_q.wdog_mode) begin  // [RULE13]
        count_d = count_q + 16'h0001;
      end else begin
        count_d = count_q - 16'h0001;  // [RULE4]
      end
    end
    // Service write: reload, clear interrupt; an event in the same cycle keeps its interrupt set
    // A failed secure check still reloads; the reset pulse follows
    if (svc_wr) begin
      count_d = reload_q;  // [RULE1] [RULE8]
      irq_d = fire & ctrl_q.irq_mode | overflow;  // [RULE19] [RULE23]
      if (!ctrl_q.wdog_mode) begin
        lfsr_d = pwdata[7:0];  // Seed before watchdog entry
      end else if (ctrl_q.secure && !secure_bad) begin
        lfsr_d = lfsr_next;  // [RULE21]
      end
    end
    if (secure_bad) begin
      rst_cnt_d = wdt_pkg::RST_PULSE_CYC;  // [RULE22]
    end
    rst_req_d = (rst_cnt_d != 3'h0);
  end

  // Timer core registers; presetn is the power-on reset only
  // Count and configuration survive every other reset of the system
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin  // [RULE10]
      ctrl_q <= wdt_pkg::wdt_ctrl_t'(wdt_pkg::CONTROL_RESET);
      reload_q <= wdt_pkg::RELOAD_RESET;  // [RULE18]
      count_q <= wdt_pkg::COUNT_RESET;  // [RULE18]
      capture_q <= wdt_pkg::CAPTURE_RESET;
      pre_q <= 8'h00;
      lfsr_q <= wdt_pkg::LFSR_RESET;
      irq_q <= 1'b0;
      rst_cnt_q <= 3'h0;
      rst_req_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      reload_q <= reload_d;
      count_q <= count_d;
      capture_q <= capture_d;
      pre_q <= pre_d;
      lfsr_q <= lfsr_d;
      irq_q <= irq_d;
      rst_cnt_q <= rst_cnt_d;
      rst_req_q <= rst_req_d;
    end
  end

  // Outputs straight from flip-flops
  // No logic after the flops, so no glitch leaves the block
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_irq = irq_q;
  assign wdog_reset_req = rst_req_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Setup cycle followed by a one-cycle answer
  sequence s_apb_setup;
    psel & ~penable;
  endsequence
  sequence s_apb_answer;
    pready ##1 !pready;
  endsequence
  // Reset request pulse of fixed width
  sequence s_rst_pulse;
    wdog_reset_req [*4] ##1 !wdog_reset_req;
  endsequence

  a_apb_answer_time: assert property (s_apb_setup |=> s_apb_answer)
    else $error("APB answer not in one cycle");
  a_service_reload: assert property (svc_wr && !fire && !overflow |=> count_q == $past(reload_q)) // [RULE8]
    else $error("Service write did not reload count");
  a_ctrl_locked: assert property (ctrl_q.wdog_mode |=> ctrl_q == $past(ctrl_q)) // [RULE9]
    else $error("Control changed in watchdog mode");
  a_reload_locked: assert property (ctrl_q.wdog_mode |=> $stable(reload_q)) // [RULE9]
    else $error("Reload changed in watchdog mode");
  a_wdog_reset_fire: assert property (fire && !ctrl_q.irq_mode |=> s_rst_pulse) // [RULE7]
    else $error("Watchdog expiry gave no reset pulse");
  a_wdog_irq_fire: assert property (fire && ctrl_q.irq_mode |=> timer_irq && !wdog_reset_req) // [RULE7]
    else $error("Watchdog expiry gave no interrupt");
  a_irq_sticky: assert property (timer_irq && !svc_wr |=> timer_irq) // [RULE23]
    else $error("Interrupt dropped without service");
  a_irq_clear: assert property (svc_wr && !fire && !overflow |=> !timer_irq) // [RULE19]
    else $error("Service write did not clear interrupt");
  a_debug_halt: assert property (sys_in.debug_halt && !svc_wr |=> $stable(count_q)) // [RULE11]
    else $error("Counter moved during debug halt");
  a_secure_mismatch: assert property (secure_bad |=> wdog_reset_req [*4]) // [RULE21]
    else $error("Secure clear mismatch gave no reset");
  a_secure_advance: assert property (svc_wr && ctrl_q.wdog_mode && ctrl_q.secure && !secure_bad
                                     |=> lfsr_q == $past(lfsr_next)) // [RULE21]
    else $error("LFSR did not advance on good service");
  a_capture_event: assert property (overflow && sys_in.irq_en |=> capture_q == $past(count_q)) // [RULE3]
    else $error("Count not captured on interrupt");

  // Counting, prescaler and privacy checks
  // Disabled normal-mode timer holds its count
  a_enable_gate: assert property (!ctrl_q.enable && !ctrl_q.wdog_mode && !svc_wr // [RULE14]
                                  |=> $stable(count_q))
    else $error("Counter moved while disabled");
  // Power-down stop when bit 0 is set
  a_pd_stop: assert property (ctrl_q.stop_in_powerdown && sys_in.periph_pd && !svc_wr // [RULE12]
                              |=> $stable(count_q))
    else $error("Counter moved during power-down");
  // Up-count steps by one between overflows
  a_up_step: assert property (tick && ctrl_q.count_up && !ctrl_q.wdog_mode // [RULE13]
                              && !overflow && !svc_wr |=> count_q == $past(count_q) + 16'h0001)
    else $error("Counter did not step up");
  // Watchdog steps down by one until zero
  a_down_step: assert property (tick && ctrl_q.wdog_mode && !fire && !svc_wr // [RULE4]
                                |=> count_q == $past(count_q) - 16'h0001)
    else $error("Watchdog did not step down");
  // Periodic overflow reloads
  a_periodic_reload: assert property (overflow && ctrl_q.periodic && !svc_wr // [RULE15]
                                      |=> count_q == $past(reload_q))
    else $error("Periodic overflow did not reload");
  // Free-running overflow wraps to the far end
  a_free_wrap: assert property (overflow && !ctrl_q.periodic && !svc_wr // [RULE15]
                                |=> count_q == ($past(ctrl_q.count_up) ?
                                                wdt_pkg::COUNT_MIN : wdt_pkg::COUNT_MAX))
    else $error("Free-running overflow did not wrap");
  // Every overflow raises the interrupt
  a_overflow_irq: assert property (overflow |=> timer_irq) // [RULE23]
    else $error("Overflow raised no interrupt");
  // Capture only moves on an overflow
  a_capture_hold: assert property (!overflow |=> $stable(capture_q)) // [RULE3]
    else $error("Capture changed without an event");
  // Zero service value in secure watchdog mode always resets
  a_secure_zero: assert property (svc_wr && ctrl_q.wdog_mode && ctrl_q.secure // [RULE22]
                                  && pwdata[7:0] == 8'h00 |=> wdog_reset_req)
    else $error("Zero service value gave no reset");
  // Reading the service word never shows the LFSR
  a_lfsr_hidden: assert property (setup_ph && !pwrite && hit_svc // [RULE22]
                                  |=> prdata == 32'h0000_0000)
    else $error("Service read returned nonzero data");
  // Divide-by-one ticks on every filtered oscillator rise
  a_div1_tick: assert property (ctrl_q.presc == wdt_pkg::PRESC_DIV1 && pre_q == 8'h00 // [RULE17]
                                && osc_rise && !halted && ctrl_q.enable |-> tick)
    else $error("Divide-by-one missed a tick");
  // Divide-by-16 ticks only at its last prescaler count
  a_div16_hold: assert property (ctrl_q.presc == wdt_pkg::PRESC_DIV16 // [RULE2]
                                 && pre_q != wdt_pkg::DIV16_LAST |-> !tick)
    else $error("Tick between divide-by-16 points");

endmodule : wdt_top

// File: rtl/wdt_pkg.sv
// Package for the 16-bit watchdog / general timer: offsets, field layout,
// reset values and cycle counts.
// Assumes one 100 MHz APB clock and a 32.768 kHz oscillator pin.
package wdt_pkg;

  // Byte addresses of the registers on the APB
  localparam logic [31:0] ADDR_RELOAD = 32'hffff0360;
  localparam logic [31:0] ADDR_COUNT = 32'hffff0364;
  localparam logic [31:0] ADDR_CONTROL = 32'hffff0368;
  localparam logic [31:0] ADDR_SERVICE = 32'hffff036c;
  localparam logic [31:0] ADDR_CAPTURE = 32'hffff0370;

  // Values after power-on reset
  localparam logic [15:0] RELOAD_RESET = 16'h03d7;
  localparam logic [15:0] COUNT_RESET = 16'h03d7;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [7:0] LFSR_RESET = 8'h00;

  // Writable control bits; bits 15:9 always store zero
  localparam logic [15:0] CONTROL_WMASK = 16'h01ff;

  // Prescaler codes of control bits 3:2
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV16 = 2'h1;
  localparam logic [1:0] PRESC_DIV256 = 2'h2;
  localparam logic [7:0] DIV16_LAST = 8'h0f;
  localparam logic [7:0] DIV256_LAST = 8'hff;

  // Feedback taps of X8 + X6 + X5 + X + 1, shifted towards bit 7
  localparam logic [7:0] LFSR_TAPS = 8'h63;

  // Count extremes
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_MIN = 16'h0000;

  // Clock rate and watchdog reset pulse width
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 32_768;
  localparam int unsigned RST_PULSE_NS = 40;
  localparam int unsigned RST_PULSE_CYC_I = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [2:0] RST_PULSE_CYC = 3'(RST_PULSE_CYC_I);

  // Control register layout, bit 15 first
  typedef struct packed {
    logic [6:0] rsvd;     // Bits 15:9, read as zero
    logic count_up;       // Bit 8
    logic enable;         // Bit 7
    logic periodic;       // Bit 6
    logic wdog_mode;      // Bit 5
    logic secure;         // Bit 4
    logic [1:0] presc;    // Bits 3:2
    logic irq_mode;       // Bit 1
    logic stop_in_powerdown; // Bit 0
  } wdt_ctrl_t;

  // System-side status inputs travelling together
  typedef struct packed {
    logic debug_halt;     // Debugger owns the core
    logic periph_pd;      // Peripherals powered down
    logic irq_en;         // Interrupt enable mask bit for this timer
  } wdt_sys_t;

endpackage : wdt_pkg

// File: verif/wdt_tb_top.sv
// Self-checking bench for the 16-bit watchdog / general timer.
// Assumes rtl/wdt_pkg.sv and rtl/wdt_top.sv are compiled first.
`timescale 1ns/100ps
module wdt_tb_top;
  // Clock, reset and APB
  logic pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr;
  // Oscillator, status and events
  logic osc_32k, timer_irq, wdog_reset_req;
  wdt_pkg::wdt_sys_t sys_in;
  // Scoreboard and model state
  int failures, n_checks, cyc, cnt;
  logic [31:0] rd, rv;
  logic err, seen;
  logic [7:0] lf;

  wdt_top u_wdt_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_32k(osc_32k), .sys_in(sys_in),
    .timer_irq(timer_irq), .wdog_reset_req(wdog_reset_req)
  );

  // 100 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Free-running 32.768 kHz oscillator, unrelated to pclk
  initial begin
    osc_32k = 1'b0;
    forever #15259 osc_32k = ~osc_32k;
  end

  // Hang guard: about 50k cycles expected
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      report_and_stop();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic is_wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is seen high; only the hang guard bounds this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Bounded wait for irq (w=0) or reset request (w=1)
  task automatic wait_ev(input bit w, input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge pclk);
      if ((w ? wdog_reset_req : timer_irq) === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
  endtask : wait_ev

  // Power-on reset, the only reset that clears the lock
  task automatic por();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : por

  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sys_in = '0;
    failures = 0;
    n_checks = 0;
    void'($urandom(33));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and refused accesses
    rdc(wdt_pkg::ADDR_RELOAD, 32'h3d7);
    rdc(wdt_pkg::ADDR_COUNT, 32'h3d7);
    rdc(wdt_pkg::ADDR_CONTROL, 32'h0);
    apb(1'b1, wdt_pkg::ADDR_COUNT, 32'h1234);
    chk(err, 1'b1);
    apb(1'b0, 32'hffff0374, 32'h0);
    chk(err, 1'b1);
    // Service write loads a random reload value
    rv = $urandom & 32'hffff;
    wr(wdt_pkg::ADDR_RELOAD, rv);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    rdc(wdt_pkg::ADDR_COUNT, rv);
    // Periodic down-count overflow raises a held interrupt
    sys_in.irq_en <= 1'b1;
    wr(wdt_pkg::ADDR_RELOAD, 32'h2);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    wr(wdt_pkg::ADDR_CONTROL, 32'hc0);
    rdc(wdt_pkg::ADDR_CONTROL, 32'hc0);
    wait_ev(1'b0, 14000);
    chk(seen, 1'b1);
    repeat (100) @(posedge pclk);
    chk(timer_irq, 1'b1);
    wr(wdt_pkg::ADDR_SERVICE, 32'h5a);
    @(posedge pclk);
    chk(timer_irq, 1'b0);
    rdc(wdt_pkg::ADDR_CAPTURE, 32'h0);
    // Free-running down-count wraps to full scale
    wr(wdt_pkg::ADDR_CONTROL, 32'h0);
    wr(wdt_pkg::ADDR_RELOAD, 32'h0);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    wr(wdt_pkg::ADDR_CONTROL, 32'h80);
    wait_ev(1'b0, 4000);
    chk(seen, 1'b1);
    rdc(wdt_pkg::ADDR_COUNT, 32'hffff);
    // Up-count held off by the debugger, then released
    wr(wdt_pkg::ADDR_CONTROL, 32'h0);
    wr(wdt_pkg::ADDR_RELOAD, 32'h10);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    sys_in.debug_halt <= 1'b1;
    wr(wdt_pkg::ADDR_CONTROL, 32'h180);
    repeat (7000) @(posedge pclk);
    rdc(wdt_pkg::ADDR_COUNT, 32'h10);
    sys_in.debug_halt <= 1'b0;
    repeat (7000) @(posedge pclk);
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    chk(32'(rd >= 32'h12 && rd <= 32'h13), 32'h1);
    // Stop during peripheral power-down when bit 0 is set
    wr(wdt_pkg::ADDR_CONTROL, 32'h181);
    sys_in.periph_pd <= 1'b1;
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    rv = rd;
    repeat (7000) @(posedge pclk);
    rdc(wdt_pkg::ADDR_COUNT, rv);
    sys_in.periph_pd <= 1'b0;
    // Divide-by-16 holds the count over a few oscillator periods
    wr(wdt_pkg::ADDR_CONTROL, 32'h84);
    apb(1'b0, wdt_pkg::ADDR_COUNT, 32'h0);
    rv = rd;
    repeat (7000) @(posedge pclk);
    rdc(wdt_pkg::ADDR_COUNT, rv);
    // Watchdog in interrupt mode, then locked registers
    por();
    wr(wdt_pkg::ADDR_RELOAD, 32'h1);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    wr(wdt_pkg::ADDR_CONTROL, 32'h22);
    wait_ev(1'b0, 9000);
    chk(seen, 1'b1);
    wr(wdt_pkg::ADDR_RELOAD, 32'h5);
    wr(wdt_pkg::ADDR_CONTROL, 32'h0);
    rdc(wdt_pkg::ADDR_RELOAD, 32'h1);
    rdc(wdt_pkg::ADDR_CONTROL, 32'h22);
    // Watchdog in reset mode: four-cycle request, config kept
    por();
    wr(wdt_pkg::ADDR_RELOAD, 32'h1);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    wr(wdt_pkg::ADDR_CONTROL, 32'h20);
    wait_ev(1'b1, 9000);
    chk(seen, 1'b1);
    cnt = 1;
    repeat (6) begin
      @(posedge pclk);
      if (wdog_reset_req === 1'b1) cnt++;
    end
    chk(cnt, 4);
    rdc(wdt_pkg::ADDR_CONTROL, 32'h20);
    // Secure clear: seed, three good values, then a wrong one
    por();
    wr(wdt_pkg::ADDR_RELOAD, 32'hffff);
    wr(wdt_pkg::ADDR_SERVICE, 32'haa);
    rdc(wdt_pkg::ADDR_SERVICE, 32'h0);
    wr(wdt_pkg::ADDR_CONTROL, 32'h32);
    lf = 8'haa;
    for (int i = 0; i < 3; i++) begin
      wr(wdt_pkg::ADDR_SERVICE, {24'h0, lf});
      wait_ev(1'b1, 10);
      chk(seen, 1'b0);
      lf = {lf[6:0], 1'b0} ^ (lf[7] ? 8'h63 : 8'h00);
    end
    wr(wdt_pkg::ADDR_SERVICE, 32'h66);
    wait_ev(1'b1, 10);
    chk(seen, 1'b1);
    // Zero seed: a zero service value resets even though it matches
    por();
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    wr(wdt_pkg::ADDR_CONTROL, 32'h32);
    wr(wdt_pkg::ADDR_SERVICE, 32'h0);
    wait_ev(1'b1, 10);
    chk(seen, 1'b1);
    report_and_stop();
  end

endmodule : wdt_tb_top
